// ### rtl/ebt_pkg.sv
// ebt_pkg: register map, field positions and reset values of the dual 8-bit compare timer
package ebt_pkg;
    // register byte offsets (apb, one word each)
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAGS      = 8'h04;
    localparam logic [7:0] OFS_CPU_IRQ    = 8'h08;
    localparam logic [7:0] OFS_TMR_BASE   = 8'h10;
    localparam logic [7:0] OFS_TMR_STRIDE = 8'h20;
    localparam logic [7:0] OFS_CNT        = 8'h00;
    localparam logic [7:0] OFS_CTL        = 8'h04;
    localparam logic [7:0] OFS_CCTL0      = 8'h08;
    localparam logic [7:0] OFS_CC0        = 8'h0c;
    localparam logic [7:0] OFS_CCTL1      = 8'h10;
    localparam logic [7:0] OFS_CC1        = 8'h14;
    // timer control fields
    localparam int CTL_DIV_LSB  = 5;
    localparam int CTL_START    = 4;
    localparam int CTL_OVERFLOW_IRQ_MASK    = 3;
    localparam int CTL_CLR      = 2;
    localparam int CTL_MODE_LSB = 0;
    localparam logic [7:0] CTL_RESET = 8'h08;
    // channel control fields
    localparam int CCTL_IM      = 6;
    localparam int CCTL_CMP_LSB = 3;
    localparam int CCTL_EN      = 2;
    localparam logic [7:0] CCTL_RESET = 8'h40;
    localparam logic [7:0] CC_RESET   = 8'h00;
    // clock control: tick speed field
    localparam int CLK_TICK_LSB = 3;
    localparam logic [7:0] CLK_RESET = 8'h00;
    // flag register bit positions: per timer ovf, ch0, ch1
    localparam int FLG_OVF = 0;
    localparam int FLG_CH0 = 1;
    localparam int FLG_CH1 = 2;
    localparam int FLG_STRIDE = 3;
    // counting modes
    localparam logic [1:0] MODE_FREE   = 2'h0;
    localparam logic [1:0] MODE_DOWN   = 2'h1;
    localparam logic [1:0] MODE_MODULO = 2'h2;
    localparam logic [1:0] MODE_UPDOWN = 2'h3;
    // compare output actions
    localparam logic [2:0] ACT_SET      = 3'h0;
    localparam logic [2:0] ACT_CLEAR    = 3'h1;
    localparam logic [2:0] ACT_TOGGLE   = 3'h2;
    localparam logic [2:0] ACT_SET_UP   = 3'h3;
    localparam logic [2:0] ACT_CLR_UP   = 3'h4;
    localparam logic [2:0] ACT_SET_CFF  = 3'h5;
    localparam logic [2:0] ACT_CLR_S00  = 3'h6;
    // interrupt vector numbers
    localparam logic [4:0] VEC_FIRST  = 5'h0b;
    localparam logic [4:0] VEC_SECOND = 5'h0c;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_TOP  = 8'hff;
endpackage : ebt_pkg

// ### rtl/ebt_timer.sv
// ebt_timer: one 8-bit timer with prescaler, four modes and two compare channels
`timescale 1ns/100ps
module ebt_timer (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] div_i,
    input  wire logic       start_i,
    input  wire logic       clr_i,
    input  wire logic [1:0] mode_i,
    input  wire logic [7:0] cc0_i,
    input  wire logic [7:0] cc1_i,
    input  wire logic [2:0] act0_i,
    input  wire logic [2:0] act1_i,
    input  wire logic       en0_i,
    input  wire logic       en1_i,
    output logic [7:0]      count_o,
    output logic            ovf_o,
    output logic            ch0_o,
    output logic            ch1_o,
    output logic            pin0_o,
    output logic            pin1_o
);
    logic [6:0] pre_q;
    logic       edge_s;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] cc0_q;
    logic       down_q;
    logic       down_d;
    logic       loaded_q;
    logic       ovf_s;
    logic       turn_s;
    logic       m0_s;
    logic       m1_s;

    // prescaler: active edge when the low div bits of the tick counter are all ones
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= 7'h00;
        end else if (tick_i && start_i) begin
            pre_q <= pre_q + 7'h01;
        end
    end
    always_comb begin
        edge_s = tick_i & start_i;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(div_i)) begin
                edge_s = edge_s & pre_q[i];
            end
        end
    end

    // channel 0 compare value latched only at zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cc0_q <= ebt_pkg::CC_RESET;
        end else if (cnt_q == ebt_pkg::CNT_ZERO) begin
            cc0_q <= cc0_i;
        end
    end

    always_comb begin
        cnt_d  = cnt_q;
        down_d = down_q;
        ovf_s  = 1'b0;
        turn_s = 1'b0;
        case (mode_i)
            ebt_pkg::MODE_FREE: begin
                down_d = 1'b0;
                cnt_d  = cnt_q + 8'h01;
                ovf_s  = (cnt_q == ebt_pkg::CNT_TOP);
            end
            ebt_pkg::MODE_MODULO: begin
                down_d = 1'b0;
                if (cnt_q == cc0_q) begin
                    cnt_d = ebt_pkg::CNT_ZERO;
                    ovf_s = 1'b1;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            ebt_pkg::MODE_DOWN: begin
                down_d = 1'b1;
                if (!loaded_q) begin
                    cnt_d = cc0_q;
                end else if (cnt_q != ebt_pkg::CNT_ZERO) begin
                    cnt_d = cnt_q - 8'h01;
                    ovf_s = (cnt_q == 8'h01);
                end
            end
            ebt_pkg::MODE_UPDOWN: begin
                if (!down_q && cnt_q == cc0_q) begin
                    down_d = 1'b1;
                    cnt_d  = (cnt_q == ebt_pkg::CNT_ZERO) ? cnt_q : cnt_q - 8'h01;
                end else if (down_q && cnt_q == ebt_pkg::CNT_ZERO) begin
                    down_d = 1'b0;
                    cnt_d  = cnt_q + 8'h01;
                    ovf_s  = 1'b1;
                    turn_s = 1'b1;
                end else if (down_q) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q    <= ebt_pkg::CNT_ZERO;
            down_q   <= 1'b0;
            loaded_q <= 1'b0;
        end else if (clr_i) begin
            cnt_q    <= ebt_pkg::CNT_ZERO;
            down_q   <= 1'b0;
            loaded_q <= 1'b0;
        end else if (!start_i) begin
            loaded_q <= 1'b0;
        end else if (edge_s) begin
            cnt_q    <= cnt_d;
            down_q   <= down_d;
            loaded_q <= 1'b1;
        end
    end

    // compare events, one per active edge on a match; in up/down mode ch0 fires once per turn at zero instead
    assign m0_s = edge_s && !clr_i && (cnt_q == cc0_q);
    assign m1_s = edge_s && !clr_i && (cnt_q == cc1_i);
    assign ovf_o = edge_s && !clr_i && ovf_s;
    assign ch0_o = (mode_i == ebt_pkg::MODE_UPDOWN) ? (edge_s && !clr_i && turn_s) : m0_s;
    assign ch1_o = m1_s;
    assign count_o = cnt_q;

    function automatic logic pin_next(input logic cur, input logic [2:0] act, input logic m,
                                      input logic at_zero, input logic at_top,
                                      input logic dn, input logic ud);
        logic r;
        r = cur;
        case (act)
            ebt_pkg::ACT_SET:     if (m) r = 1'b1;
            ebt_pkg::ACT_CLEAR:   if (m) r = 1'b0;
            ebt_pkg::ACT_TOGGLE:  if (m) r = ~cur;
            ebt_pkg::ACT_SET_UP: begin
                if (m && !(ud && dn)) r = 1'b1;
                else if (ud ? (m && dn) : at_zero) r = 1'b0;
            end
            ebt_pkg::ACT_CLR_UP: begin
                if (m && !(ud && dn)) r = 1'b0;
                else if (ud ? (m && dn) : at_zero) r = 1'b1;
            end
            ebt_pkg::ACT_SET_CFF: begin
                if (m) r = 1'b1;
                else if (at_top) r = 1'b0;
            end
            ebt_pkg::ACT_CLR_S00: begin
                if (m) r = 1'b0;
                else if (at_zero) r = 1'b1;
            end
            default: r = cur;
        endcase
        return r;
    endfunction : pin_next

    // output pins are flip-flops, so every edge is glitch free
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin0_o <= 1'b0;
            pin1_o <= 1'b0;
        end else if (edge_s && !clr_i) begin
            if (en0_i) begin
                pin0_o <= pin_next(pin0_o, act0_i, m0_s, cnt_q == ebt_pkg::CNT_ZERO,
                                   cnt_q == ebt_pkg::CNT_TOP, down_q,
                                   mode_i == ebt_pkg::MODE_UPDOWN);
            end
            if (en1_i) begin
                pin1_o <= pin_next(pin1_o, act1_i, m1_s, cnt_q == ebt_pkg::CNT_ZERO,
                                   cnt_q == ebt_pkg::CNT_TOP, down_q,
                                   mode_i == ebt_pkg::MODE_UPDOWN);
            end
        end
    end
endmodule : ebt_timer

// ### rtl/ebt_top.sv
// ebt_top: apb register file, tick divider, flags and interrupt logic of two 8-bit timers
`timescale 1ns/100ps
module ebt_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [1:0]       cmp_pin_o [2],
    output logic [1:0]       dma_trig_o [2],
    output logic [1:0]       irq_req_o,
    output logic [4:0]       irq_vector_o [2]
);
    logic [7:0] clk_ctrl_q;
    logic [7:0] ctl_q   [2];
    logic [7:0] cctl0_q [2];
    logic [7:0] cctl1_q [2];
    logic [7:0] cc0_q   [2];
    logic [7:0] cc1_q   [2];
    logic [5:0] flags_q;
    logic [1:0] irq_en_q;
    logic [1:0] cpu_flag_q;
    logic [6:0] tick_q;
    logic       tick_s;
    logic       wr_s;
    logic       rd_ok_s;
    logic [7:0] rd_s;
    logic [1:0] clr_s;
    logic [7:0] count_s [2];
    logic [1:0] ovf_s;
    logic [1:0] ch0_s;
    logic [1:0] ch1_s;
    logic [5:0] ev_s;
    logic [5:0] msk_s;
    logic [5:0] fclr_s;
    logic [5:0] rise_s;
    logic [5:0] pend_q;

    assign wr_s      = psel_i & penable_i & pwrite_i;
    assign pready_o  = 1'b1;

    // tick divider: tick speed field divides system clock by 2^n, clock itself untouched
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= 7'h00;
        end else begin
            tick_q <= tick_q + 7'h01;
        end
    end
    always_comb begin
        tick_s = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(clk_ctrl_q[ebt_pkg::CLK_TICK_LSB +: 3])) begin
                tick_s = tick_s & tick_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clk_ctrl_q <= ebt_pkg::CLK_RESET;
            irq_en_q   <= 2'h0;
        end else if (wr_s && paddr_i == ebt_pkg::OFS_CLOCK_CTRL) begin
            clk_ctrl_q <= pwdata_i[7:0] & 8'h38;
        end else if (wr_s && paddr_i == ebt_pkg::OFS_CPU_IRQ) begin
            irq_en_q <= pwdata_i[1:0];
        end
    end

    // per-timer register file and timer core
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        localparam logic [7:0] BASE = 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE);
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                ctl_q[t]   <= ebt_pkg::CTL_RESET;
                cctl0_q[t] <= ebt_pkg::CCTL_RESET;
                cctl1_q[t] <= ebt_pkg::CCTL_RESET;
                cc0_q[t]   <= ebt_pkg::CC_RESET;
                cc1_q[t]   <= ebt_pkg::CC_RESET;
            end else if (wr_s) begin
                if (paddr_i == BASE + ebt_pkg::OFS_CTL) begin
                    ctl_q[t] <= pwdata_i[7:0] & 8'hfb;
                end
                if (paddr_i == BASE + ebt_pkg::OFS_CCTL0) begin
                    cctl0_q[t] <= pwdata_i[7:0] & 8'h7c;
                end
                if (paddr_i == BASE + ebt_pkg::OFS_CCTL1) begin
                    cctl1_q[t] <= pwdata_i[7:0] & 8'h7c;
                end
                if (paddr_i == BASE + ebt_pkg::OFS_CC0) begin
                    cc0_q[t] <= pwdata_i[7:0];
                end
                if (paddr_i == BASE + ebt_pkg::OFS_CC1) begin
                    cc1_q[t] <= pwdata_i[7:0];
                end
            end
        end
        assign clr_s[t] = wr_s && paddr_i == BASE + ebt_pkg::OFS_CTL
                          && pwdata_i[ebt_pkg::CTL_CLR];

        ebt_timer u_timer (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .tick_i    (tick_s),
            .div_i     (ctl_q[t][ebt_pkg::CTL_DIV_LSB +: 3]),
            .start_i   (ctl_q[t][ebt_pkg::CTL_START]),
            .clr_i     (clr_s[t]),
            .mode_i    (ctl_q[t][ebt_pkg::CTL_MODE_LSB +: 2]),
            .cc0_i     (cc0_q[t]),
            .cc1_i     (cc1_q[t]),
            .act0_i    (cctl0_q[t][ebt_pkg::CCTL_CMP_LSB +: 3]),
            .act1_i    (cctl1_q[t][ebt_pkg::CCTL_CMP_LSB +: 3]),
            .en0_i     (cctl0_q[t][ebt_pkg::CCTL_EN]),
            .en1_i     (cctl1_q[t][ebt_pkg::CCTL_EN]),
            .count_o   (count_s[t]),
            .ovf_o     (ovf_s[t]),
            .ch0_o     (ch0_s[t]),
            .ch1_o     (ch1_s[t]),
            .pin0_o    (cmp_pin_o[t][0]),
            .pin1_o    (cmp_pin_o[t][1])
        );

        assign ev_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_OVF] = ovf_s[t];
        assign ev_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_CH0] = ch0_s[t];
        assign ev_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_CH1] = ch1_s[t];
        assign msk_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_OVF] = ctl_q[t][ebt_pkg::CTL_OVERFLOW_IRQ_MASK];
        assign msk_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_CH0] = cctl0_q[t][ebt_pkg::CCTL_IM];
        assign msk_s[t*ebt_pkg::FLG_STRIDE + ebt_pkg::FLG_CH1] = cctl1_q[t][ebt_pkg::CCTL_IM];

        // dma triggers: one-cycle pulse per compare event
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                dma_trig_o[t] <= 2'h0;
            end else begin
                dma_trig_o[t] <= {ch1_s[t], ch0_s[t]};
            end
        end
        assign irq_vector_o[t] = (t == 0) ? ebt_pkg::VEC_FIRST : ebt_pkg::VEC_SECOND;
    end

    // timer flags: software writes 0 to clear a bit; a same-cycle event wins
    assign fclr_s = (wr_s && paddr_i == ebt_pkg::OFS_FLAGS) ? ~pwdata_i[5:0] : 6'h00;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= (flags_q & ~fclr_s) | ev_s;
        end
    end

    // a masked-in flag that is newly pending (event or mask enabled) raises the cpu flag
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 6'h00;
        end else begin
            pend_q <= flags_q & msk_s;
        end
    end
    assign rise_s = flags_q & msk_s & ~pend_q;

    for (genvar t = 0; t < 2; t++) begin : g_cpu
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                cpu_flag_q[t] <= 1'b0;
            end else if (|rise_s[t*3 +: 3]) begin
                cpu_flag_q[t] <= 1'b1;
            end else if (wr_s && paddr_i == ebt_pkg::OFS_CPU_IRQ && !pwdata_i[t + 8]) begin
                cpu_flag_q[t] <= 1'b0;
            end
        end
    end
    assign irq_req_o = cpu_flag_q & irq_en_q;

    // read mux
    always_comb begin
        rd_s    = 8'h00;
        rd_ok_s = 1'b1;
        case (paddr_i)
            ebt_pkg::OFS_CLOCK_CTRL: rd_s = clk_ctrl_q;
            ebt_pkg::OFS_FLAGS:      rd_s = {2'h0, flags_q};
            ebt_pkg::OFS_CPU_IRQ:    rd_s = {6'h00, irq_en_q};
            default: begin
                rd_ok_s = 1'b0;
                for (int t = 0; t < 2; t++) begin
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CNT) begin
                        rd_s = count_s[t];
                        rd_ok_s = 1'b1;
                    end
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CTL) begin
                        rd_s = ctl_q[t];
                        rd_ok_s = 1'b1;
                    end
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CCTL0) begin
                        rd_s = cctl0_q[t];
                        rd_ok_s = 1'b1;
                    end
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CC0) begin
                        rd_s = cc0_q[t];
                        rd_ok_s = 1'b1;
                    end
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CCTL1) begin
                        rd_s = cctl1_q[t];
                        rd_ok_s = 1'b1;
                    end
                    if (paddr_i == 8'(ebt_pkg::OFS_TMR_BASE + t * ebt_pkg::OFS_TMR_STRIDE)
                                   + ebt_pkg::OFS_CC1) begin
                        rd_s = cc1_q[t];
                        rd_ok_s = 1'b1;
                    end
                end
            end
        endcase
    end

    // read data and error registered in setup phase, shown during access
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h000000, rd_s};
            pslverr_o <= ~rd_ok_s;
        end
    end
endmodule : ebt_top

// ### verification/ebt_assertions.sv
// ebt_assertions: port-level checks of the dual 8-bit compare timer
`timescale 1ns/100ps
module ebt_assertions (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic [1:0]  cmp_pin_o [2],
    input  wire logic [1:0]  dma_trig_o [2],
    input  wire logic [1:0]  irq_req_o,
    input  wire logic [4:0]  irq_vector_o [2]
);
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && ((a <= 8'h08) || ((a >= 8'h10) && (a <= 8'h24))
            || ((a >= 8'h30) && (a <= 8'h44)));
    endfunction : mapped
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    zero_wait_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready low in access phase");
    upper_zero_a: assert property (psel_i && penable_i && !pwrite_i
        |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    unmapped_err_a: assert property (psel_i && penable_i && !mapped(paddr_i)
        |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel_i && penable_i && mapped(paddr_i) |-> !pslverr_o)
        else $error("mapped access refused");
    vec_first_a: assert property (irq_vector_o[0] == ebt_pkg::VEC_FIRST)
        else $error("first timer vector wrong");
    vec_second_a: assert property (irq_vector_o[1] == ebt_pkg::VEC_SECOND)
        else $error("second timer vector wrong");
    release_idle_a: assert property ($fell(rst_i) |-> irq_req_o == 2'h0
        && cmp_pin_o[0] == 2'h0 && cmp_pin_o[1] == 2'h0)
        else $error("outputs not idle after reset");
    irq_fall_a: assert property ($fell(irq_req_o[0]) || $fell(irq_req_o[1])
        |-> $past(psel_i && penable_i && pwrite_i))
        else $error("irq request dropped without a write");
endmodule : ebt_assertions

// ### verification/ebt_top_tb.sv
// ebt_top_tb: apb-driven self-checking bench of the dual 8-bit compare timer
`timescale 1ns/100ps
module ebt_top_tb;
    logic        clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, d, e;
    logic [1:0]  cmp_pin_o [2], dma_trig_o [2], irq_req_o;
    logic [4:0]  irq_vector_o [2];
    int          err_count = 0, samples_checked = 0, tg, pl;
    logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h34, 8'h0c};
    logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00, 8'h08, 8'h00};
    logic [31:0] mt [5] = '{32'h001a0514, 32'h003a050a, 32'h005a0505, 32'h081a050a, 32'h001a0b0a};
    ebt_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_pin_o(cmp_pin_o),
        .dma_trig_o(dma_trig_o), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        d = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : xfer
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic watch(input int t, input int c, input int n);
        logic p;
        tg = 0;
        pl = 0;
        p = cmp_pin_o[t][c];
        repeat (n) begin
            @(posedge clk_sys_i);
            if (cmp_pin_o[t][c] !== p) tg++;
            if (dma_trig_o[t][c] === 1'b1) pl++;
            p = cmp_pin_o[t][c];
        end
    endtask : watch
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        cyc(20000);
        err_count++;
        report_and_stop();
    end
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        rst_i = 1'b1;
        cyc(16);
        rst_i <= 1'b0;
        foreach (ra[i]) begin
            xfer(1'b0, ra[i], 32'h0);
            chk("reset value", {24'h0, rv[i]}, d);
        end
        xfer(1'b1, 8'h0c, 32'hff);
        xfer(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, d);
        xfer(1'b1, 8'h14, 32'h10);
        xfer(1'b0, 8'h10, 32'h0);
        e = d;
        xfer(1'b0, 8'h10, 32'h0);
        chk("count step", 32'h3, (d - e) & 32'hff);
        cyc(300);
        xfer(1'b0, 8'h04, 32'h0);
        chk("t0 overflow flag", 32'h1, d & 32'h1);
        xfer(1'b1, 8'h08, 32'h1);
        cyc(2);
        chk("irq masked", 32'h0, irq_req_o[0]);
        xfer(1'b1, 8'h14, 32'h18);
        cyc(2);
        chk("irq on mask", 32'h1, irq_req_o[0]);
        xfer(1'b1, 8'h14, 32'h08);
        xfer(1'b0, 8'h10, 32'h0);
        e = d;
        cyc(5);
        xfer(1'b0, 8'h10, 32'h0);
        chk("frozen count", e, d);
        xfer(1'b1, 8'h14, 32'h0c);
        xfer(1'b0, 8'h10, 32'h0);
        chk("cleared count", 32'h0, d);
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h08, 32'h1);
        cyc(2);
        chk("irq cleared", 32'h0, irq_req_o[0]);
        xfer(1'b1, 8'h24, 32'h80);
        xfer(1'b1, 8'h14, 32'h10);
        for (int a = 0; a < 7; a++) begin
            xfer(1'b1, 8'h20, 32'h4 | (a << 3));
            cyc(300);
            watch(0, 1, 512);
            chk("ch1 edges", (a == 2) ? 2 : (a < 2) ? 0 : 4, tg);
            chk("ch1 dma", 32'h2, pl);
            if (a < 2) chk("ch1 level", a == 0, cmp_pin_o[0][1]);
        end
        xfer(1'b1, 8'h38, 32'h54);
        foreach (mt[i]) begin
            xfer(1'b1, 8'h00, {24'h0, mt[i][31:24]});
            xfer(1'b1, 8'h3c, {24'h0, mt[i][15:8]});
            xfer(1'b1, 8'h34, {24'h0, mt[i][23:16]});
            cyc(60);
            watch(1, 0, 120);
            chk("ch0 toggles", mt[i][7:0], tg);
            chk("ch0 dma", mt[i][7:0], pl);
        end
        xfer(1'b0, 8'h04, 32'h0);
        chk("t1 flags", 32'h18, d & 32'h18);
        xfer(1'b1, 8'h3c, 32'h5);
        xfer(1'b1, 8'h34, 32'h1b);
        cyc(40);
        xfer(1'b1, 8'h04, 32'h0);
        repeat (8) begin
            xfer(1'b0, 8'h30, 32'h0);
            chk("updown range", 32'h1, d <= 32'h5);
        end
        xfer(1'b0, 8'h04, 32'h0);
        chk("updown flags", 32'h18, d & 32'h18);
        xfer(1'b1, 8'h08, 32'h303);
        chk("t1 irq", 32'h1, irq_req_o[1]);
        xfer(1'b1, 8'h14, 32'h0c);
        xfer(1'b1, 8'h1c, 32'h4);
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h14, 32'h19);
        cyc(20);
        xfer(1'b0, 8'h10, 32'h0);
        chk("down end", 32'h0, d);
        xfer(1'b0, 8'h04, 32'h0);
        chk("down flag", 32'h1, d & 32'h1);
        report_and_stop();
    end
endmodule : ebt_top_tb
bind ebt_top ebt_assertions chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_pin_o(cmp_pin_o),
    .dma_trig_o(dma_trig_o), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o));
